/* File: logic/irq_priority_and_trigger_logic.sv */
module irq_priority_and_trigger_logic #(
  parameter int LEVELS = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [irq_ctl_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // CPU core instructions
  input wire logic disable_interrupts_instr_i,
  input wire logic enable_interrupts_instr_i,
  input wire logic return_from_interrupt_instr_i,
  input wire logic [31:0] return_psw_i,
  input wire logic load_system_register_instr_i,
  input wire logic [31:0] load_psw_i,
  // CPU core acknowledge
  input wire logic nmi_ack_i,
  input wire logic exception_ack_i,
  input wire logic mi_ack_i,
  input wire logic [4:0] mi_ack_src_i,
  input wire logic [2:0] mi_ack_level_i,
  output logic mi_req_o,
  output logic [23:0] mi_pending_o,
  output logic [LEVELS-1:0] in_service_levels_o,
  output logic maskable_disable_flag_o,
  // External pins
  input wire logic [15:0] level_capable_irq_pin_n_i,
  input wire logic [3:0] capture_irq_pin_a_i,
  input wire logic [3:0] capture_irq_pin_b_i,
  // Trigger outputs
  output logic [3:0] capture_trig_a_o,
  output logic [3:0] capture_trig_b_o,
  output logic [3:0] timer_count_o,
  output logic conv_trig_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ****************************************
  // Declarations
  // ****************************************
  localparam int NS = irq_ctl_pkg::NUM_SRC;

  logic [31:0] psw_r;
  logic [31:0] psw_nxt;
  logic [LEVELS-1:0] isr_r;
  logic [LEVELS-1:0] isr_set;
  logic [LEVELS-1:0] isr_clr;
  logic [7:0] group_mode_r [4];
  logic [5:0] edge_sel_r [4];
  logic [2:0] conv_mode_r;
  logic [NS-1:0] mask_r;
  logic [NS-1:0] flag_r;
  logic [NS-1:0] flag_set;
  logic [NS-1:0] flag_clr;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NS-1:0] prev_r;
  logic [3:0] timer_hit;
  logic conv_hit;
  logic sample_tick_r;
  logic bus_ack_r;
  logic wr_en;
  logic [31:0] rd_data;
  logic [31:0] mask_wr;
  logic [2:0] warm_r;

  // Edge test on two consecutive synchronized samples
  function automatic logic edge_hit(input logic [1:0] m, input logic prev, input logic cur);
    logic hit;
    hit = 1'b0;
    case (m)
      irq_ctl_pkg::TRIG_FALL: hit = prev & ~cur;
      irq_ctl_pkg::TRIG_RISE: hit = ~prev & cur;
      irq_ctl_pkg::TRIG_BOTH: hit = prev ^ cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  // Merge written bytes into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // One wait state: data is registered in the first cycle, taken in the second
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack_r;
  assign wr_en = avs_write_i & bus_ack_r;
  assign mask_wr = be_merge({8'h00, mask_r}, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack_r <= 1'b0;
    end else begin
      bus_ack_r <= (avs_read_i | avs_write_i) & ~bus_ack_r;
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    case (avs_address_i)
      irq_ctl_pkg::IN_SERVICE_ADDR: rd_data[LEVELS-1:0] = isr_r;
      irq_ctl_pkg::PSW_ADDR: rd_data = psw_r;
      irq_ctl_pkg::GROUP_MODE_ADDR0: rd_data[7:0] = group_mode_r[0];
      irq_ctl_pkg::GROUP_MODE_ADDR0 + 10'h001: rd_data[7:0] = group_mode_r[1];
      irq_ctl_pkg::GROUP_MODE_ADDR0 + 10'h002: rd_data[7:0] = group_mode_r[2];
      irq_ctl_pkg::GROUP_MODE_ADDR0 + 10'h003: rd_data[7:0] = group_mode_r[3];
      irq_ctl_pkg::EDGE_SEL_ADDR0: rd_data[5:0] = edge_sel_r[0];
      irq_ctl_pkg::EDGE_SEL_ADDR0 + 10'h001: rd_data[5:0] = edge_sel_r[1];
      irq_ctl_pkg::EDGE_SEL_ADDR0 + 10'h002: rd_data[5:0] = edge_sel_r[2];
      irq_ctl_pkg::EDGE_SEL_ADDR0 + 10'h003: rd_data[5:0] = edge_sel_r[3];
      irq_ctl_pkg::REQ_FLAG_ADDR: rd_data[NS-1:0] = flag_r;
      irq_ctl_pkg::MASK_ADDR: rd_data[NS-1:0] = mask_r;
      irq_ctl_pkg::CONV_MODE_ADDR: rd_data[2:0] = conv_mode_r;
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !bus_ack_r) begin
      avs_readdata_o <= rd_data;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Trigger mode is not checked against the port mode; order is software's job
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < 4; g++) begin
        group_mode_r[g] <= irq_ctl_pkg::GROUP_MODE_RESET;
        edge_sel_r[g] <= irq_ctl_pkg::EDGE_SEL_RESET;
      end
      conv_mode_r <= irq_ctl_pkg::CONV_MODE_RESET;
      mask_r <= irq_ctl_pkg::MASK_RESET;
    end else if (wr_en) begin
      for (int g = 0; g < 4; g++) begin
        if (avs_address_i == irq_ctl_pkg::GROUP_MODE_ADDR0 + 10'(g) && avs_byteenable_i[0]) begin
          group_mode_r[g] <= avs_writedata_i[7:0];
        end
        if (avs_address_i == irq_ctl_pkg::EDGE_SEL_ADDR0 + 10'(g) && avs_byteenable_i[0]) begin
          edge_sel_r[g] <= avs_writedata_i[5:0];
        end
      end
      if (avs_address_i == irq_ctl_pkg::CONV_MODE_ADDR && avs_byteenable_i[0]) begin
        conv_mode_r <= avs_writedata_i[2:0];
      end
      if (avs_address_i == irq_ctl_pkg::MASK_ADDR) begin
        mask_r <= mask_wr[NS-1:0];
      end
    end
  end

  // ****************************************
  // Processor status word
  // ****************************************
  always_comb begin
    psw_nxt = psw_r;
    if (wr_en && avs_address_i == irq_ctl_pkg::PSW_ADDR) begin
      psw_nxt = be_merge(psw_r, avs_writedata_i, avs_byteenable_i);
    end
    if (load_system_register_instr_i) begin
      psw_nxt = load_psw_i;
    end
    if (return_from_interrupt_instr_i) begin
      psw_nxt = return_psw_i;
    end
    if (disable_interrupts_instr_i) begin
      psw_nxt[irq_ctl_pkg::PSW_ID_BIT] = 1'b1;
    end
    if (enable_interrupts_instr_i) begin
      psw_nxt[irq_ctl_pkg::PSW_ID_BIT] = 1'b0;
    end
    // Acknowledge wins over any same-cycle load so a new handler starts masked
    if (mi_ack_i || nmi_ack_i || exception_ack_i) begin
      psw_nxt[irq_ctl_pkg::PSW_ID_BIT] = 1'b1;
    end
    if (nmi_ack_i) begin
      psw_nxt[irq_ctl_pkg::PSW_NP_BIT] = 1'b1;
    end
    if (nmi_ack_i || exception_ack_i) begin
      psw_nxt[irq_ctl_pkg::PSW_EP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      psw_r <= irq_ctl_pkg::PSW_RESET;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  assign maskable_disable_flag_o = psw_r[irq_ctl_pkg::PSW_ID_BIT];

  // ****************************************
  // In-service levels
  // ****************************************
  always_comb begin
    isr_set = '0;
    isr_clr = '0;
    if (mi_ack_i) begin
      isr_set[mi_ack_level_i] = 1'b1;
    end
    // Status word still shows the servicing kind at the return
    if (return_from_interrupt_instr_i && !psw_r[irq_ctl_pkg::PSW_NP_BIT]
        && !psw_r[irq_ctl_pkg::PSW_EP_BIT]) begin
      isr_clr = isr_r & (~isr_r + LEVELS'(1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      isr_r <= LEVELS'(irq_ctl_pkg::IN_SERVICE_RESET);
    end else begin
      isr_r <= (isr_r & ~isr_clr) | isr_set;
    end
  end

  assign in_service_levels_o = isr_r;

  // ****************************************
  // Pin synchronizers and sample tick
  // ****************************************
  assign pin_raw = {capture_irq_pin_b_i[3], capture_irq_pin_a_i[3],
                    capture_irq_pin_b_i[2], capture_irq_pin_a_i[2],
                    capture_irq_pin_b_i[1], capture_irq_pin_a_i[1],
                    capture_irq_pin_b_i[0], capture_irq_pin_a_i[0],
                    level_capable_irq_pin_n_i};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r <= '1;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Divider of two: a tick every other clock
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sample_tick_r <= 1'b0;
    end else begin
      sample_tick_r <= ~sample_tick_r;
    end
  end

  // Edge tests wait until prev holds a real pin sample, so reset gives no false edge
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      warm_r <= 3'h0;
    end else begin
      warm_r <= {warm_r[1:0], 1'b1};
    end
  end

  // ****************************************
  // Detection per source
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < NS; i++) begin : g_src
      logic [1:0] mode;
      logic hit;
      if (i < irq_ctl_pkg::GROUP_PINS) begin : g_grp
        assign mode = group_mode_r[i / 4][2 * (i % 4) +: 2];
        // Level mode is only reachable on group pins
        assign hit = (mode == irq_ctl_pkg::TRIG_LEVEL)
                     ? (sample_tick_r & ~sync2_r[i])
                     : (warm_r[2] & edge_hit(mode, prev_r[i], sync2_r[i]));
      end else begin : g_cap
        assign mode = edge_sel_r[(i - 16) / 2][2 + 2 * ((i - 16) % 2) +: 2];
        assign hit = warm_r[2] & edge_hit(mode, prev_r[i], sync2_r[i]);
      end
      always_comb begin
        flag_set[i] = hit;
        flag_clr[i] = 1'b0;
        if (mi_ack_i && mi_ack_src_i == 5'(i)) begin
          flag_clr[i] = 1'b1;
        end
        if (wr_en && avs_address_i == irq_ctl_pkg::REQ_FLAG_ADDR
            && avs_byteenable_i[i / 8] && !avs_writedata_i[i]) begin
          flag_clr[i] = 1'b1;
        end
      end
    end
    for (i = 0; i < 4; i++) begin : g_tmr
      assign timer_hit[i] = warm_r[2] & edge_hit(edge_sel_r[i][1:0], prev_r[16 + 2 * i],
                                                 sync2_r[16 + 2 * i]);
    end
  endgenerate

  // Shared pin uses its group edge bits for the converter
  assign conv_hit = (conv_mode_r == irq_ctl_pkg::CONV_EXT_MODE) && warm_r[2]
                    && edge_hit(group_mode_r[2][7:6],
                                prev_r[irq_ctl_pkg::CONV_SHARED_SRC],
                                sync2_r[irq_ctl_pkg::CONV_SHARED_SRC]);

  // ****************************************
  // Request flags and triggers
  // ****************************************
  // A set in the same cycle as a clear wins, so no edge is lost
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= irq_ctl_pkg::REQ_FLAG_RESET;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      capture_trig_a_o <= 4'h0;
      capture_trig_b_o <= 4'h0;
      timer_count_o <= 4'h0;
      conv_trig_o <= 1'b0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        capture_trig_a_o[c] <= flag_set[16 + 2 * c];
        capture_trig_b_o[c] <= flag_set[17 + 2 * c];
      end
      timer_count_o <= timer_hit;
      conv_trig_o <= conv_hit;
    end
  end

  // ****************************************
  // Request to the core
  // ****************************************
  assign mi_pending_o = flag_r & ~mask_r;
  // Disable flag holds requests back; NMI and exceptions bypass this path
  assign mi_req_o = (|mi_pending_o) & ~psw_r[irq_ctl_pkg::PSW_ID_BIT];

endmodule : irq_priority_and_trigger_logic

/* File: logic/irq_ctl_pkg.sv */
// ****************************************
// Register map, reset values, encodings
// ****************************************
package irq_ctl_pkg;

  // Bus word address width
  localparam int ADDR_W = 10;

  // Printed index of the in-service register; the bus decodes its low bits
  localparam logic [31:0] IN_SERVICE_IDX = 32'hFFFFF1FA;
  localparam logic [ADDR_W-1:0] IN_SERVICE_ADDR = IN_SERVICE_IDX[ADDR_W-1:0];
  localparam logic [ADDR_W-1:0] PSW_ADDR = 10'h1F0;
  localparam logic [ADDR_W-1:0] GROUP_MODE_ADDR0 = 10'h1E0;
  localparam logic [ADDR_W-1:0] EDGE_SEL_ADDR0 = 10'h1E4;
  localparam logic [ADDR_W-1:0] REQ_FLAG_ADDR = 10'h1E8;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 10'h1E9;
  localparam logic [ADDR_W-1:0] CONV_MODE_ADDR = 10'h1EA;

  // Reset values
  localparam logic [31:0] PSW_RESET = 32'h00000020;
  localparam logic [7:0] IN_SERVICE_RESET = 8'h00;
  localparam logic [7:0] GROUP_MODE_RESET = 8'h00;
  localparam logic [5:0] EDGE_SEL_RESET = 6'h00;
  localparam logic [23:0] MASK_RESET = 24'hFFFFFF;
  localparam logic [23:0] REQ_FLAG_RESET = 24'h000000;
  localparam logic [2:0] CONV_MODE_RESET = 3'h0;

  // Status word bit positions
  localparam int PSW_ID_BIT = 5;
  localparam int PSW_EP_BIT = 6;
  localparam int PSW_NP_BIT = 7;

  // Trigger selection encodings
  localparam logic [1:0] TRIG_FALL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_LEVEL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;

  // Converter trigger mode value that selects the external input
  localparam logic [2:0] CONV_EXT_MODE = 3'h6;

  // Source layout: 16 group pins, then pin a / pin b per capture channel
  localparam int GROUP_PINS = 16;
  localparam int NUM_SRC = 24;
  localparam int CONV_SHARED_SRC = 11;

  // Level pins are sampled once per this many clocks
  localparam int LEVEL_SAMPLE_DIV = 2;

endpackage : irq_ctl_pkg

/* File: tb/irq_ctl_monitor.sv */
// ****************************************
// Port checker
// ****************************************
module irq_ctl_monitor #(
  parameter int LEVELS = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // CPU side
  input wire logic disable_interrupts_instr_i,
  input wire logic enable_interrupts_instr_i,
  input wire logic return_from_interrupt_instr_i,
  input wire logic nmi_ack_i,
  input wire logic exception_ack_i,
  input wire logic mi_ack_i,
  input wire logic [2:0] mi_ack_level_i,
  input wire logic mi_req_o,
  input wire logic [23:0] mi_pending_o,
  input wire logic [LEVELS-1:0] in_service_levels_o,
  input wire logic maskable_disable_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_ack_sets_level:
    assert property (mi_ack_i |=> in_service_levels_o[$past(mi_ack_level_i)])
    else $error("acknowledged level not marked in service");
  a_ack_sets_flag:
    assert property (mi_ack_i |=> maskable_disable_flag_o)
    else $error("flag clear after acknowledge");
  a_dis_sets_flag:
    assert property (disable_interrupts_instr_i && !enable_interrupts_instr_i
      |=> maskable_disable_flag_o)
    else $error("flag clear after disable");
  a_ena_clears_flag:
    assert property (enable_interrupts_instr_i && !mi_ack_i && !nmi_ack_i && !exception_ack_i
      |=> !maskable_disable_flag_o)
    else $error("flag set after enable");
  a_flag_blocks_req:
    assert property (maskable_disable_flag_o |-> !mi_req_o)
    else $error("request raised while disabled");
  a_pending_requests:
    assert property (!maskable_disable_flag_o && mi_pending_o != '0 |-> mi_req_o)
    else $error("unmasked pending source not requested");
  a_in_service_holds:
    assert property (!mi_ack_i && !return_from_interrupt_instr_i
      |=> $stable(in_service_levels_o))
    else $error("in-service changed without cause");
  a_return_clears_one:
    assert property (return_from_interrupt_instr_i && !mi_ack_i
      |=> (in_service_levels_o & ~$past(in_service_levels_o)) == '0
      && $countones($past(in_service_levels_o)) <= $countones(in_service_levels_o) + 1)
    else $error("return changed more than one in-service bit");
  a_nmi_sets_flag:
    assert property (nmi_ack_i |=> maskable_disable_flag_o)
    else $error("flag clear after nmi acknowledge");
endmodule : irq_ctl_monitor

/* File: tb/cpu_core_model.sv */
// ****************************************
// CPU core: acknowledges the lowest pending source
// ****************************************
module cpu_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bench control
  input wire logic en_i,
  input wire logic [3:0] delay_i,
  // Controller side
  input wire logic mi_req_i,
  input wire logic [23:0] mi_pending_i,
  output logic mi_ack_o,
  output logic [4:0] src_o,
  output logic [2:0] level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  logic [4:0] low_idx;
  always_comb begin
    low_idx = 5'h00;
    for (int i = 23; i >= 0; i--) begin
      if (mi_pending_i[i]) begin
        low_idx = 5'(i);
      end
    end
  end
  // A slow answer restarts if the request drops meanwhile
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mi_ack_o <= 1'b0;
      wait_r <= 4'h0;
      src_o <= 5'h00;
      level_o <= 3'h0;
    end else begin
      mi_ack_o <= 1'b0;
      if (!en_i || !mi_req_i || mi_ack_o) begin
        wait_r <= 4'h0;
      end else if (wait_r < delay_i) begin
        wait_r <= wait_r + 4'h1;
      end else begin
        mi_ack_o <= 1'b1;
        src_o <= low_idx;
        level_o <= low_idx[2:0];
      end
    end
  end
endmodule : cpu_core_model

/* File: tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic wr;
    logic [irq_ctl_pkg::ADDR_W-1:0] a;
    logic [31:0] d;
    logic [31:0] exp;
  } row_t;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [irq_ctl_pkg::ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic waitreq;
  logic [5:0] ins = '0;
  logic [31:0] ret_psw = '0;
  logic cpu_en = 1'b0;
  logic [3:0] cpu_dly = '0;
  logic mi_ack;
  logic [4:0] ack_src;
  logic [2:0] ack_lvl;
  logic mi_req;
  logic [23:0] pend;
  logic [7:0] isr;
  logic dflag;
  logic [15:0] gpin = 16'hFFFF;
  logic [3:0] pa = '0;
  logic [3:0] pb = '0;
  logic [3:0] cap_a;
  logic [3:0] cap_b;
  logic [3:0] tmr;
  logic conv;
  logic [31:0] rd;
  int fail_count = 0;
  int comparisons = 0;
  int n_a = 0;
  int n_b = 0;
  int n_t = 0;
  int n_c = 0;
  logic [1:0] modes[4] = '{irq_ctl_pkg::TRIG_FALL, irq_ctl_pkg::TRIG_RISE,
    irq_ctl_pkg::TRIG_LEVEL, irq_ctl_pkg::TRIG_BOTH};
  row_t rows[5] = '{
    '{1'b0, irq_ctl_pkg::PSW_ADDR, 32'h0, irq_ctl_pkg::PSW_RESET},
    '{1'b1, irq_ctl_pkg::IN_SERVICE_ADDR, 32'hFF, 32'h0},
    '{1'b1, 10'h000, 32'hA5A5A5A5, 32'h0},
    '{1'b0, irq_ctl_pkg::MASK_ADDR, 32'h0, {8'h00, irq_ctl_pkg::MASK_RESET}},
    '{1'b1, irq_ctl_pkg::GROUP_MODE_ADDR0, 32'h5A, 32'h5A}};

  always #50 clk_i = ~clk_i;

  irq_priority_and_trigger_logic #(.LEVELS(8)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(addr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .disable_interrupts_instr_i(ins[0]), .enable_interrupts_instr_i(ins[1]),
    .return_from_interrupt_instr_i(ins[2]), .return_psw_i(ret_psw),
    .load_system_register_instr_i(ins[3]), .load_psw_i(32'h0),
    .nmi_ack_i(ins[4]), .exception_ack_i(ins[5]), .mi_ack_i(mi_ack),
    .mi_ack_src_i(ack_src), .mi_ack_level_i(ack_lvl), .mi_req_o(mi_req),
    .mi_pending_o(pend), .in_service_levels_o(isr), .maskable_disable_flag_o(dflag),
    .level_capable_irq_pin_n_i(gpin), .capture_irq_pin_a_i(pa), .capture_irq_pin_b_i(pb),
    .capture_trig_a_o(cap_a), .capture_trig_b_o(cap_b), .timer_count_o(tmr),
    .conv_trig_o(conv));

  cpu_core_model cpu_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .en_i(cpu_en), .delay_i(cpu_dly),
    .mi_req_i(mi_req), .mi_pending_i(pend), .mi_ack_o(mi_ack), .src_o(ack_src),
    .level_o(ack_lvl));

  always @(posedge clk_i) begin
    n_a <= n_a + int'(cap_a[0] === 1'b1);
    n_b <= n_b + int'(cap_b[0] === 1'b1);
    n_t <= n_t + int'(tmr[0] === 1'b1);
    n_c <= n_c + int'(conv === 1'b1);
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request stands until a rising edge sees waitrequest low; only the watchdog ends a hang
  task bus_xfer(input logic wr, input logic [irq_ctl_pkg::ADDR_W-1:0] a,
      input logic [31:0] d);
    @(posedge clk_i);
    wr_en <= wr;
    rd_en <= !wr;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk_i);
    end while (waitreq !== 1'b0);
    chk("bus answer", 32'h0, {31'h0, waitreq});
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus_xfer

  task instr(input logic [5:0] v);
    @(posedge clk_i);
    ins <= v;
    @(posedge clk_i);
    ins <= '0;
  endtask : instr

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs about 250 clocks; this margin only catches a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        bus_xfer(1'b1, rows[i].a, rows[i].d);
      end
      bus_xfer(1'b0, rows[i].a, 32'h0);
      chk("register", rows[i].exp, rd);
    end
    $display("register rows done");
    // ****************************************
    // Group pin trigger modes
    // ****************************************
    for (int m = 0; m < 4; m++) begin
      bus_xfer(1'b1, irq_ctl_pkg::GROUP_MODE_ADDR0, {30'h0, modes[m]});
      bus_xfer(1'b1, irq_ctl_pkg::REQ_FLAG_ADDR, 32'h0);
      gpin[0] <= 1'b0;
      repeat (6) @(posedge clk_i);
      bus_xfer(1'b0, irq_ctl_pkg::REQ_FLAG_ADDR, 32'h0);
      chk("fall flag", {28'h0, 4'b1101 >> m & 4'h1}, rd);
      bus_xfer(1'b1, irq_ctl_pkg::REQ_FLAG_ADDR, 32'h0);
      gpin[0] <= 1'b1;
      repeat (6) @(posedge clk_i);
      bus_xfer(1'b0, irq_ctl_pkg::REQ_FLAG_ADDR, 32'h0);
      chk("rise flag", {28'h0, 4'b1110 >> m & 4'h1}, rd);
      bus_xfer(1'b1, irq_ctl_pkg::REQ_FLAG_ADDR, 32'h0);
      bus_xfer(1'b0, irq_ctl_pkg::REQ_FLAG_ADDR, 32'h0);
      chk("cleared flag", 32'h0, rd);
    end
    $display("trigger modes done");
    // ****************************************
    // Capture, timer and converter triggers
    // ****************************************
    bus_xfer(1'b1, irq_ctl_pkg::EDGE_SEL_ADDR0, 32'h05);
    bus_xfer(1'b1, irq_ctl_pkg::CONV_MODE_ADDR, {29'h0, irq_ctl_pkg::CONV_EXT_MODE});
    bus_xfer(1'b1, irq_ctl_pkg::GROUP_MODE_ADDR0 + 10'h2, 32'h40);
    gpin[11] <= 1'b0;
    pa[0] <= 1'b1;
    pb[0] <= 1'b1;
    repeat (8) @(posedge clk_i);
    gpin[11] <= 1'b1;
    pa[0] <= 1'b0;
    pb[0] <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk("capture a", 32'h1, n_a);
    chk("capture b", 32'h1, n_b);
    chk("timer count", 32'h1, n_t);
    chk("converter", 32'h1, n_c);
    $display("trigger outputs done");
    // ****************************************
    // Acknowledge, nesting and return
    // ****************************************
    bus_xfer(1'b1, irq_ctl_pkg::REQ_FLAG_ADDR, 32'h0);
    bus_xfer(1'b1, irq_ctl_pkg::MASK_ADDR, 32'h00FFFFD7);
    gpin[3] <= 1'b0;
    gpin[5] <= 1'b0;
    cpu_en <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk("held request", 32'h0, {31'h0, mi_req});
    chk("pending", 32'h28, {8'h0, pend});
    instr(6'h02);
    repeat (6) @(negedge clk_i);
    chk("flag after ack", 32'h1, {31'h0, dflag});
    chk("pending after ack", 32'h20, {8'h0, pend});
    bus_xfer(1'b0, irq_ctl_pkg::IN_SERVICE_ADDR, 32'h0);
    chk("in-service read", 32'h08, rd);
    cpu_dly <= 4'h3;
    instr(6'h02);
    repeat (10) @(negedge clk_i);
    chk("nested", 32'h28, {24'h0, isr});
    ret_psw <= irq_ctl_pkg::PSW_RESET;
    instr(6'h04);
    @(negedge clk_i);
    chk("return", 32'h20, {24'h0, isr});
    for (int k = 0; k < 2; k++) begin
      instr(k == 0 ? 6'h10 : 6'h20);
      @(negedge clk_i);
      chk("flag on nmi or exception", 32'h1, {31'h0, dflag});
      instr(6'h04);
      @(negedge clk_i);
      chk("kept in-service", 32'h20, {24'h0, isr});
    end
    instr(6'h04);
    @(negedge clk_i);
    chk("last return", 32'h0, {24'h0, isr});
    instr(6'h08);
    @(negedge clk_i);
    chk("loaded flag", 32'h0, {31'h0, dflag});
    instr(6'h01);
    bus_xfer(1'b0, irq_ctl_pkg::PSW_ADDR, 32'h0);
    chk("status word", irq_ctl_pkg::PSW_RESET, rd);
    $display("acknowledge flow done");
    report_and_stop();
  end
endmodule : tb

bind irq_priority_and_trigger_logic irq_ctl_monitor #(.LEVELS(LEVELS)) mon_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .disable_interrupts_instr_i(disable_interrupts_instr_i),
  .enable_interrupts_instr_i(enable_interrupts_instr_i),
  .return_from_interrupt_instr_i(return_from_interrupt_instr_i), .nmi_ack_i(nmi_ack_i),
  .exception_ack_i(exception_ack_i),
  .mi_ack_i(mi_ack_i), .mi_ack_level_i(mi_ack_level_i), .mi_req_o(mi_req_o),
  .mi_pending_o(mi_pending_o), .in_service_levels_o(in_service_levels_o),
  .maskable_disable_flag_o(maskable_disable_flag_o));
